/* verif/msf_operator_model.sv */
`timescale 1ns/1ps
`default_nettype none
module msf_operator_model (
    // clock and device answer
    input  wire logic        clk,
    input  wire logic        writeRejected,
    // contacts and keypad
    output var logic         selLow,
    output var logic         selMid,
    output var logic         selHigh,
    output var logic         selExtra,
    output var logic         startCmd,
    output var logic         keypadMode,
    output var logic         paramWrite,
    output var logic [4:0]   paramSelect,
    output var logic [15:0]  paramData
);
    // idle at time zero: contacts open, stopped, terminal mode, no write
    initial begin
        {selLow, selMid, selHigh, selExtra, startCmd, keypadMode} = 6'h00;
        paramWrite = 1'b0;
        paramSelect = 5'h00;
        paramData = 16'h0000;
    end
    // all four select functions are allocated to terminals
    task automatic contacts(input logic [3:0] lmhx);
        @(posedge clk);
        #1 {selLow, selMid, selHigh, selExtra} = lmhx;
    endtask
    // run request and operation mode
    task automatic mode(input logic start, input logic keypad);
        @(posedge clk);
        #1 {startCmd, keypadMode} = {start, keypad};
    endtask
    // one write strobe, then watch two cycles for a refusal pulse
    task automatic wr(input logic [4:0] sel, input logic [15:0] data, output logic rej);
        @(posedge clk);
        #1 {paramWrite, paramSelect, paramData} = {1'b1, sel, data};
        @(posedge clk);
        #1 paramWrite = 1'b0;
        rej = writeRejected;
        @(posedge clk);
        #1 rej = rej | writeRejected;
    endtask
endmodule
`default_nettype wire

/* verif/tb_msf_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_msf_top
    import msf_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        analogValid = 1'b0;
    logic [15:0] analogFreq = 16'h0000;
    wire logic   selLow, selMid, selHigh, selExtra, startCmd, keypadMode, paramWrite;
    wire logic   running, writeRejected, changePending;
    wire logic [4:0]  paramSelect;
    wire logic [15:0] paramData, outFreq, targetFreq, baseFreqEff, boostEff, upperLimit;
    logic [15:0] tab [15];
    logic        rej;
    int          error_cnt = 0;
    int          samples_checked = 0;
    localparam int CODE [8] = '{0, 1, 2, 6, 3, 5, 4, 7};

    always #20 clk = ~clk;

    msf_top dut (.clk(clk), .reset(reset), .selLow(selLow), .selMid(selMid),
        .selHigh(selHigh), .selExtra(selExtra), .startCmd(startCmd), .keypadMode(keypadMode),
        .analogValid(analogValid), .analogFreq(analogFreq), .paramWrite(paramWrite),
        .paramSelect(paramSelect), .paramData(paramData), .outFreq(outFreq),
        .targetFreq(targetFreq), .baseFreqEff(baseFreqEff), .boostEff(boostEff),
        .upperLimit(upperLimit), .running(running), .writeRejected(writeRejected),
        .changePending(changePending));
    msf_operator_model op (.clk(clk), .writeRejected(writeRejected), .selLow(selLow),
        .selMid(selMid), .selHigh(selHigh), .selExtra(selExtra), .startCmd(startCmd),
        .keypadMode(keypadMode), .paramWrite(paramWrite), .paramSelect(paramSelect),
        .paramData(paramData));

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_out(input logic [15:0] v, output int n);
        n = 0;
        while (outFreq !== v && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    // expected command from contacts {low, mid, high, extra} and mirrored table
    function automatic logic [15:0] expSel(input logic [3:0] k);
        int n;
        n = CODE[k[3:1]];
        if (k[0] && n == 0) return (tab[7] !== FREQ_UNSET) ? tab[7] : analogFreq;
        if (k[0] && tab[n + 7] !== FREQ_UNSET) return tab[n + 7];
        if (n >= 4 && tab[n - 1] === FREQ_UNSET) n = k[3] ? 3 : (k[2] ? 2 : 1);
        return (n == 0) ? analogFreq : tab[n - 1];
    endfunction

    task automatic t_reset;
        check(upperLimit, RST_UPPER, "upper after reset");
        check(baseFreqEff, RST_BASE_FREQ, "base after reset");
        check(boostEff, RST_BOOST, "boost after reset");
        check({outFreq[15:1], running}, 16'h0000, "idle after reset");
        $display("test reset done");
    endtask
    task automatic t_ramp;
        int n;
        op.wr(SEL_RAMP_REF, 16'h9C40, rej);
        op.wr(SEL_ACCEL, 16'h0001, rej);
        op.wr(SEL_DECEL, 16'h0001, rej);
        op.wr(SEL_BASE_FREQ, 16'h1388, rej);
        analogFreq = 16'h0064;
        analogValid = 1'b1;
        op.mode(1'b1, 1'b0);
        wait_out(16'h0064, n);
        check(16'(n >= 600 && n <= 660), 16'h0001, "accel cycles");
        check({baseFreqEff[15:1], running}, 16'h1389, "base and running");
        op.wr(SEL_VECTOR, 16'h0001, rej);
        check({15'h0, changePending}, 16'h0001, "pending while running");
        check(boostEff, RST_BOOST, "boost held while running");
        op.wr(SEL_DECEL, 16'h0000, rej);
        op.mode(1'b0, 1'b0);
        wait_out(16'h0000, n);
        check(16'(n >= 2450 && n <= 2560), 16'h0001, "decel zero time");
        tick(3);
        check({14'h0, running, changePending}, 16'h0000, "stopped and applied");
        check(baseFreqEff, VECTOR_BASE_FREQ, "vector base");
        check(boostEff, 16'h0000, "vector boost");
        op.wr(SEL_RAMP_SHAPE, 16'h0001, rej);
        op.mode(1'b1, 1'b0);
        wait_out(16'h0064, n);
        check(16'(n >= 4100 && n <= 4250), 16'h0001, "base ramp");
        op.wr(SEL_ACCEL, RST_RAMP_TIME, rej);
        op.wr(SEL_DECEL, RST_RAMP_TIME, rej);
        $display("test ramp done");
    endtask
    task automatic t_decode(input logic fill);
        for (int i = 0; i < 15; i++) begin
            if (fill && i % 3 != 1) begin
                tab[i] = 16'(1000 + 300 * i);
                op.wr(5'(i), tab[i], rej);
            end
        end
        op.mode(1'b1, fill);
        for (int i = 0; i < 16; i++) begin
            op.contacts(4'(i));
            tick(3);
            check(targetFreq, expSel(4'(i)), "preset");
        end
        $display("test decode done");
    endtask
    task automatic t_limits;
        op.contacts(4'b0010);
        op.wr(SEL_UPPER, 16'h1388, rej);
        op.wr(5'h00, 16'h1770, rej);
        tick(3);
        check(targetFreq, 16'h1388, "upper clamp");
        op.wr(SEL_LOWER, 16'h07D0, rej);
        op.contacts(4'b1000);
        tick(3);
        check(targetFreq, 16'h07D0, "lower clamp");
        analogValid = 1'b0;
        op.contacts(4'b0000);
        tick(3);
        check(targetFreq, 16'h07D0, "start alone");
        op.wr(SEL_HIGH_UPPER, 16'h4E20, rej);
        check(upperLimit, 16'h4E20, "high range upper");
        op.wr(SEL_UPPER, 16'h32C8, rej);
        check({rej, upperLimit[14:0]}, 16'hCE20, "upper over range refused");
        $display("test limits done");
    endtask
    task automatic t_writes;
        op.contacts(4'b0010);
        op.wr(5'h00, 16'h2715, rej);
        tick(3);
        check(targetFreq, 16'h2710, "coarse step");
        op.wr(5'h00, 16'h270F, rej);
        tick(3);
        check(targetFreq, 16'h270F, "fine step while running");
        op.wr(5'h00, 16'h9C41, rej);
        check({15'h0, rej}, 16'h0001, "above 400 Hz refused");
        op.mode(1'b1, 1'b0);
        op.wr(SEL_CARRIER, 16'h0002, rej);
        check({15'h0, rej}, 16'h0001, "carrier in terminal mode");
        op.mode(1'b1, 1'b1);
        op.wr(SEL_CARRIER, 16'h0002, rej);
        check({15'h0, rej}, 16'h0000, "carrier in keypad mode");
        $display("test writes done");
    endtask

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        tab = '{default: FREQ_UNSET};
        tab[0] = RST_SPEED_ONE;
        tab[1] = RST_SPEED_TWO;
        tab[2] = RST_SPEED_THREE;
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        tick(1);
        t_reset;
        t_ramp;
        t_decode(1'b0);
        t_decode(1'b1);
        t_limits;
        t_writes;
        end_sim;
    end
    // watchdog, well beyond the expected run of about 7500 cycles
    initial begin
        #(40 * 40000);
        error_cnt++;
        end_sim;
    end
endmodule
`default_nettype wire

/* verilog/msf_pkg.sv */
package msf_pkg;
    // frequencies are held in 0.01 Hz units, times in 0.01 s units
    localparam logic [15:0] FREQ_UNSET       = 16'hFFFF;
    localparam logic [15:0] FREQ_MAX         = 16'd40000;
    localparam logic [15:0] FREQ_FINE_LIMIT  = 16'd10000;
    localparam logic [15:0] FREQ_COARSE_STEP = 16'd10;
    localparam logic [15:0] NORMAL_UPPER_MAX = 16'd12000;
    localparam logic [15:0] VECTOR_BASE_FREQ = 16'd6000;

    // timing
    localparam int          CLK_FREQ_HZ       = 25_000_000;
    localparam int          RAMP_TIME_UNIT_US = 10_000;
    localparam int          RAMP_UNIT_CYCLES  = CLK_FREQ_HZ / 1_000_000 * RAMP_TIME_UNIT_US;
    localparam int          ZERO_RAMP_TIME_US = 40_000;
    localparam logic [15:0] ZERO_RAMP_UNITS   = 16'(ZERO_RAMP_TIME_US / RAMP_TIME_UNIT_US);

    // parameter selector codes
    localparam logic [4:0] SEL_SPEED_LAST   = 5'h0E;
    localparam logic [4:0] SEL_UPPER        = 5'h0F;
    localparam logic [4:0] SEL_LOWER        = 5'h10;
    localparam logic [4:0] SEL_HIGH_UPPER   = 5'h11;
    localparam logic [4:0] SEL_START_FREQ   = 5'h12;
    localparam logic [4:0] SEL_ACCEL        = 5'h13;
    localparam logic [4:0] SEL_DECEL        = 5'h14;
    localparam logic [4:0] SEL_RAMP_REF     = 5'h15;
    localparam logic [4:0] SEL_BASE_FREQ    = 5'h16;
    localparam logic [4:0] SEL_RAMP_SHAPE   = 5'h17;
    localparam logic [4:0] SEL_VECTOR       = 5'h18;
    localparam logic [4:0] SEL_BOOST        = 5'h19;
    localparam logic [4:0] SEL_WRITE_PROT   = 5'h1A;
    localparam logic [4:0] SEL_CARRIER      = 5'h1B;
    localparam logic [4:0] SEL_METER_CAL    = 5'h1C;

    // reset values
    localparam logic [15:0] RST_SPEED_ONE   = 16'd6000;
    localparam logic [15:0] RST_SPEED_TWO   = 16'd3000;
    localparam logic [15:0] RST_SPEED_THREE = 16'd1000;
    localparam logic [15:0] RST_UPPER       = 16'd12000;
    localparam logic [15:0] RST_LOWER       = 16'd0;
    localparam logic [15:0] RST_START_FREQ  = 16'd50;
    localparam logic [15:0] RST_RAMP_TIME   = 16'd500;
    localparam logic [15:0] RST_RAMP_REF    = 16'd6000;
    localparam logic [15:0] RST_BASE_FREQ   = 16'd6000;
    localparam logic [15:0] RST_BOOST       = 16'd6;
    localparam logic [15:0] RST_CARRIER     = 16'd1;
    localparam logic [1:0]  WP_NO_WRITE     = 2'h1;

    typedef enum logic [1:0] {
        ST_STOPPED = 2'b01,
        ST_RUNNING = 2'b10
    } msf_state_t;
endpackage

/* verilog/msf_ramp.sv */
`timescale 1ns/1ps
`default_nettype none
module msf_ramp
    import msf_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // ramp settings
    input  wire logic [15:0] targetFreq,
    input  wire logic [15:0] rampRef,
    input  wire logic [15:0] accelTime,
    input  wire logic [15:0] decelTime,
    // output frequency
    output logic [15:0]      outFreq
);
    logic [39:0] acc;

    // zero ramp time stands for ZERO_RAMP_UNITS, a 0.04 s ramp
    wire logic [15:0] accEff  = (accelTime == 16'h0000) ? ZERO_RAMP_UNITS : accelTime; // see R15
    wire logic [15:0] decEff  = (decelTime == 16'h0000) ? ZERO_RAMP_UNITS : decelTime; // see R15
    wire logic        goUp    = outFreq < targetFreq;
    wire logic        goDown  = outFreq > targetFreq;
    // cycles for the reference span, one frequency unit per overflow
    wire logic [39:0] span    = 40'(goUp ? accEff : decEff) * 40'(RAMP_UNIT_CYCLES); // see R14 R21
    wire logic [39:0] inc     = 40'((rampRef == 16'h0000) ? 16'h0001 : rampRef);
    wire logic [39:0] sum     = acc + inc;
    wire logic        stepNow = sum >= span;

    // linear stepping towards the target
    always_ff @(posedge clk) begin
        if (reset) begin
            acc     <= 40'h0;
            outFreq <= 16'h0000;
        end else if (!goUp && !goDown) begin
            acc <= 40'h0;
        end else if (stepNow) begin
            acc     <= sum - span;
            outFreq <= goUp ? outFreq + 16'h0001 : outFreq - 16'h0001; // see R21
        end else begin
            acc <= sum;
        end
    end

    a_step_size: assert property (@(posedge clk) disable iff (reset) // see R21
        (outFreq - $past(outFreq) <= 16'h0001) || ($past(outFreq) - outFreq <= 16'h0001))
        else $error("output frequency jumped more than one unit");
    a_no_overshoot: assert property (@(posedge clk) disable iff (reset) // see R14
        ($past(outFreq) < $past(targetFreq)) |-> (outFreq <= $past(targetFreq)))
        else $error("ramp passed its target");
    a_hold_target: assert property (@(posedge clk) disable iff (reset) // see R21
        (outFreq == targetFreq && $stable(targetFreq)) |=> $stable(outFreq))
        else $error("output moved while at target");
endmodule
`default_nettype wire

/* verilog/msf_speed_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module msf_speed_decode
    import msf_pkg::*;
(
    // contact select inputs
    input  wire logic        selLow,
    input  wire logic        selMid,
    input  wire logic        selHigh,
    input  wire logic        selExtra,
    // preset table, entry 0 is speed one
    input  wire logic [15:0] speedTable [15],
    // resolved selection
    output logic             hasPreset,
    output logic [15:0]      presetFreq
);
    // combination code of the three base inputs, 0 when none closed
    function automatic logic [3:0] comboIndex(input logic l, input logic m, input logic h);
        if (l & m & h)       comboIndex = 4'h7;
        else if (m & h)      comboIndex = 4'h6;
        else if (l & h)      comboIndex = 4'h5;
        else if (l & m)      comboIndex = 4'h4;
        else if (l)          comboIndex = 4'h3;
        else if (m)          comboIndex = 4'h2;
        else if (h)          comboIndex = 4'h1;
        else                 comboIndex = 4'h0;
    endfunction

    wire logic [3:0] baseIdx  = comboIndex(selLow, selMid, selHigh);
    // lower-speed input wins when a combination speed is unset
    wire logic [3:0] lowPick  = selLow ? 4'h3 : (selMid ? 4'h2 : (selHigh ? 4'h1 : 4'h0)); // see R5
    wire logic       baseSet  = (baseIdx != 4'h0) && (speedTable[baseIdx - 4'h1] != FREQ_UNSET);
    wire logic [3:0] baseRes  = baseSet ? baseIdx : lowPick;                                // see R1 R2
    wire logic [3:0] extIdx   = 4'h8 + baseIdx;
    wire logic       extSet   = speedTable[extIdx - 4'h1] != FREQ_UNSET;
    // extra input: speed eight alone drops out, nine..fifteen fall back
    wire logic [3:0] finalIdx = !selExtra ? baseRes : (extSet ? extIdx : baseRes); // see R3 R4

    assign hasPreset  = finalIdx != 4'h0;
    assign presetFreq = hasPreset ? speedTable[finalIdx - 4'h1] : 16'h0000;
endmodule
`default_nettype wire

/* verilog/msf_top.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: high input alone gives speed one, mid speed two, low speed three.
// R2: two or three base inputs give speeds four to seven unless unset.
// R3: extra input alone gives speed eight unless that setting is unset.
// R4: extra plus others gives nine..fifteen, unset falls back to one..seven.
// R5: several inputs with unset combination: lower-speed input's setting wins.
// R6: preset selection beats the analog frequency setting.
// R7: presets work in keypad mode and in terminal mode alike.
// R8: settings step 0.01 Hz below 100 Hz, 0.1 Hz from there up.
// R9: presets take 0 to 400 Hz and may change while running.
// R10: configurer must map the four select functions onto terminals.
// R11: command is clamped between lower and upper limits.
// R12: high-range upper limit sets limits above 120 Hz and replaces upper.
// R13: start alone with lower limit at or above start frequency runs there.
// R14: accel 0 Hz to reference in accel time, decel likewise down.
// R15: zero ramp time counts as 0.04 seconds.
// R16: first S-shaped pattern ramps against base frequency instead.
// R17: vector control forces 60 Hz base and ignores manual boost.
// R18: stop-validated settings written while running wait for stop.
// R19: protect, carrier and meter writes only in keypad mode.
// R20: vector control disregards manual torque boost.
// R21: output moves linearly, step from reference over ramp time.
module msf_top
    import msf_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,

    // contact inputs, mapped by the input allocation
    input  wire logic        selLow,
    input  wire logic        selMid,
    input  wire logic        selHigh,
    input  wire logic        selExtra,
    input  wire logic        startCmd,

    // operation mode and analog command
    input  wire logic        keypadMode,
    input  wire logic        analogValid,
    input  wire logic [15:0] analogFreq,

    // setting write port
    input  wire logic        paramWrite,
    input  wire logic [4:0]  paramSelect,
    input  wire logic [15:0] paramData,

    // results
    output logic [15:0]      outFreq,
    output logic [15:0]      targetFreq,
    output logic [15:0]      baseFreqEff,
    output logic [15:0]      boostEff,
    output logic [15:0]      upperLimit,
    output logic             running,
    output logic             writeRejected,
    output logic             changePending
);

    // stored settings
    logic [15:0] speedTable [15];
    logic [15:0] lowerLimit;
    logic [15:0] startFreq;
    logic [15:0] accelTime;
    logic [15:0] decelTime;
    logic [15:0] rampRef;
    logic [15:0] baseFreq;
    logic [15:0] boost;
    logic [15:0] carrier;
    logic [15:0] meterCal;
    logic [1:0]  writeProt;

    // settings in force, pending copies
    logic        shapeS;
    logic        vectorOn;
    logic        pendShape;
    logic        pendVector;
    logic        pendShapeVal;
    logic        pendVectorVal;
    msf_state_t  state;
    msf_state_t  next_state;

    // coarser step at and above 100 Hz
    function automatic logic [15:0] quantize(input logic [15:0] v);
        if (v != FREQ_UNSET && v >= FREQ_FINE_LIMIT)
            quantize = v - (v % FREQ_COARSE_STEP);
        else
            quantize = v;
    endfunction

    // write classification
    wire logic        isSpeed   = paramSelect <= SEL_SPEED_LAST;
    wire logic        isFreq    = isSpeed
                                  || (paramSelect >= SEL_UPPER && paramSelect <= SEL_START_FREQ)
                                  || paramSelect == SEL_RAMP_REF || paramSelect == SEL_BASE_FREQ;
    wire logic        unsetOk   = isSpeed && paramSelect > 5'h02;
    wire logic        keypadOnly = paramSelect == SEL_WRITE_PROT || paramSelect == SEL_CARRIER
                                  || paramSelect == SEL_METER_CAL;
    wire logic        modeBad   = keypadOnly && !keypadMode;                       // see R19
    wire logic        rangeBad  = isFreq && paramData > FREQ_MAX
                                  && !(unsetOk && paramData == FREQ_UNSET);        // see R9
    wire logic        upperBad  = paramSelect == SEL_UPPER && paramData > NORMAL_UPPER_MAX;
    wire logic        protBad   = writeProt == WP_NO_WRITE && paramSelect != SEL_WRITE_PROT;
    wire logic        reject    = modeBad || rangeBad || upperBad || protBad;
    wire logic        accept    = paramWrite && !reject;
    wire logic [15:0] wData     = isFreq ? quantize(paramData) : paramData;        // see R8
    wire logic        isStopped = state == ST_STOPPED;

    // preset speeds, written at any time, also during running
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 15; i++) begin
                speedTable[i] <= FREQ_UNSET;
            end
            speedTable[0] <= RST_SPEED_ONE;
            speedTable[1] <= RST_SPEED_TWO;
            speedTable[2] <= RST_SPEED_THREE;
        end else if (accept && isSpeed) begin
            speedTable[paramSelect[3:0]] <= wData;                                 // see R9
        end
    end

    // limits and ramp settings
    always_ff @(posedge clk) begin
        if (reset) begin
            upperLimit <= RST_UPPER;
            lowerLimit <= RST_LOWER;
            startFreq  <= RST_START_FREQ;
            accelTime  <= RST_RAMP_TIME;
            decelTime  <= RST_RAMP_TIME;
            rampRef    <= RST_RAMP_REF;
            baseFreq   <= RST_BASE_FREQ;
            boost      <= RST_BOOST;
        end else if (accept) begin
            if (paramSelect == SEL_UPPER || paramSelect == SEL_HIGH_UPPER) begin
                upperLimit <= wData;                                               // see R12
            end
            if (paramSelect == SEL_LOWER)      lowerLimit <= wData;
            if (paramSelect == SEL_START_FREQ) startFreq  <= wData;
            if (paramSelect == SEL_ACCEL)      accelTime  <= wData;
            if (paramSelect == SEL_DECEL)      decelTime  <= wData;
            if (paramSelect == SEL_RAMP_REF)   rampRef    <= wData;
            if (paramSelect == SEL_BASE_FREQ)  baseFreq   <= wData;
            if (paramSelect == SEL_BOOST)      boost      <= wData;
        end
    end

    // keypad-only settings
    always_ff @(posedge clk) begin
        if (reset) begin
            writeProt <= 2'h0;
            carrier   <= RST_CARRIER;
            meterCal  <= 16'h0000;
        end else if (accept) begin
            if (paramSelect == SEL_WRITE_PROT) writeProt <= wData[1:0];            // see R19
            if (paramSelect == SEL_CARRIER)    carrier   <= wData;                 // see R19
            if (paramSelect == SEL_METER_CAL)  meterCal  <= wData;                 // see R19
        end
    end

    // stop-validated settings wait while the drive runs
    always_ff @(posedge clk) begin
        if (reset) begin
            shapeS        <= 1'b0;
            vectorOn      <= 1'b0;
            pendShape     <= 1'b0;
            pendVector    <= 1'b0;
            pendShapeVal  <= 1'b0;
            pendVectorVal <= 1'b0;
        end else begin
            if (accept && paramSelect == SEL_RAMP_SHAPE) begin
                pendShape    <= 1'b1;                                              // see R18
                pendShapeVal <= wData[0];
            end else if (pendShape && isStopped) begin
                pendShape <= 1'b0;
                shapeS    <= pendShapeVal;                                         // see R18
            end
            if (accept && paramSelect == SEL_VECTOR) begin
                pendVector    <= 1'b1;                                             // see R18
                pendVectorVal <= wData[0];
            end else if (pendVector && isStopped) begin
                pendVector <= 1'b0;
                vectorOn   <= pendVectorVal;                                       // see R18
            end
        end
    end

    // write answer
    always_ff @(posedge clk) begin
        if (reset) begin
            writeRejected <= 1'b0;
        end else begin
            writeRejected <= paramWrite && reject;                                 // see R19
        end
    end

    // preset decode from the terminals, the same in either mode
    logic        hasPreset;
    logic [15:0] presetFreq;
    msf_speed_decode u_decode (                                                    // see R7 R10
        .selLow     (selLow),
        .selMid     (selMid),
        .selHigh    (selHigh),
        .selExtra   (selExtra),
        .speedTable (speedTable),
        .hasPreset  (hasPreset),
        .presetFreq (presetFreq)
    );

    // command selection and limit clamp
    wire logic [15:0] cmdFreq = hasPreset ? presetFreq : analogFreq;                // see R6
    wire logic        noCmd   = !hasPreset && !analogValid;
    wire logic [15:0] clamped = cmdFreq > upperLimit ? upperLimit :
                                (cmdFreq < lowerLimit ? lowerLimit : cmdFreq);      // see R11
    wire logic [15:0] idleCmd = lowerLimit >= startFreq ? lowerLimit : 16'h0000;    // see R13
    wire logic [15:0] next_target = !startCmd ? 16'h0000 : (noCmd ? idleCmd : clamped);

    // vector control overrides
    wire logic [15:0] next_base  = vectorOn ? VECTOR_BASE_FREQ : baseFreq;         // see R17
    wire logic [15:0] next_boost = vectorOn ? 16'h0000 : boost;                    // see R17 R20
    wire logic [15:0] rampSpan   = shapeS ? baseFreqEff : rampRef;                 // see R16

    // drive state
    always_comb begin
        next_state = state;
        case (state)
            ST_STOPPED: if (startCmd) next_state = ST_RUNNING;
            ST_RUNNING: if (!startCmd && outFreq == 16'h0000) next_state = ST_STOPPED;
            default:    next_state = ST_STOPPED;
        endcase
    end

    // registered command outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            state       <= ST_STOPPED;
            targetFreq  <= 16'h0000;
            baseFreqEff <= RST_BASE_FREQ;
            boostEff    <= RST_BOOST;
        end else begin
            state       <= next_state;
            targetFreq  <= next_target;
            baseFreqEff <= next_base;
            boostEff    <= next_boost;
        end
    end

    assign running       = state == ST_RUNNING;
    assign changePending = pendShape || pendVector;

    msf_ramp u_ramp (
        .clk        (clk),
        .reset      (reset),
        .targetFreq (targetFreq),
        .rampRef    (rampSpan),
        .accelTime  (accelTime),
        .decelTime  (decelTime),
        .outFreq    (outFreq)
    );

    // command and setting checks
    a_clamp_upper: assert property (@(posedge clk) disable iff (reset) // see R11
        (startCmd && !noCmd) |=> (targetFreq <= $past(upperLimit)))
        else $error("target above upper limit");

    a_clamp_lower: assert property (@(posedge clk) disable iff (reset) // see R11
        (startCmd && !noCmd) |=> (targetFreq >= $past(lowerLimit)))
        else $error("target below lower limit");

    a_keypad_only: assert property (@(posedge clk) disable iff (reset) // see R19
        (paramWrite && keypadOnly && !keypadMode) |=> (writeRejected && $stable(carrier)
        && $stable(meterCal) && $stable(writeProt)))
        else $error("keypad-only setting written outside keypad mode");

    a_vector_base: assert property (@(posedge clk) disable iff (reset) // see R17 R20
        vectorOn |=> (baseFreqEff == VECTOR_BASE_FREQ && boostEff == 16'h0000))
        else $error("vector mode did not override base or boost");

    a_stop_apply: assert property (@(posedge clk) disable iff (reset) // see R18
        (running && $past(running)) |-> ($stable(vectorOn) && $stable(shapeS)))
        else $error("stop-validated setting changed while running");

    a_high_only: assert property (@(posedge clk) disable iff (reset) // see R1 R6
        (startCmd && selHigh && !selMid && !selLow && !selExtra) |=>
        (targetFreq == ($past(speedTable[0]) > $past(upperLimit) ? $past(upperLimit) :
        ($past(speedTable[0]) < $past(lowerLimit) ? $past(lowerLimit) : $past(speedTable[0])))))
        else $error("high input alone did not select speed one");

    a_start_lower: assert property (@(posedge clk) disable iff (reset) // see R13
        (startCmd && noCmd && lowerLimit >= startFreq) |=> (targetFreq == $past(lowerLimit)))
        else $error("start alone did not run at the lower limit");

    a_high_upper: assert property (@(posedge clk) disable iff (reset) // see R12
        (paramWrite && !reject && paramSelect == SEL_HIGH_UPPER) |=> (upperLimit == $past(wData)))
        else $error("high-range upper limit did not replace upper limit");

    a_refuse_keeps: assert property (@(posedge clk) disable iff (reset) // see R12
        (paramWrite && reject) |=> ($stable(upperLimit) && $stable(lowerLimit)))
        else $error("refused write changed a limit");
endmodule
`default_nettype wire
